// *** ssr_pkg.sv ***
// ============================================================
// shared constants for the strap and reset configuration block
// ============================================================
package ssr_pkg;

    // ============================================================
    // register byte offsets
    // ============================================================
    localparam logic [7:0] ADDR_LSTS0 = 8'h00; // upstream link status
    localparam logic [7:0] ADDR_LSTS1 = 8'h04; // downstream port 1 link status
    localparam logic [7:0] ADDR_LSTS2 = 8'h08; // downstream port 2 link status
    localparam logic [7:0] ADDR_LSTS3 = 8'h0c; // downstream port 3 link status
    localparam logic [7:0] ADDR_STRAP = 8'h10; // captured strap status

    // register index codes
    localparam logic [2:0] IDX_STRAP = 3'h4; // strap status index
    localparam logic [2:0] IDX_NONE = 3'h7; // unmapped address

    // ============================================================
    // link status register fields
    // ============================================================
    localparam int SCLK_BIT = 12; // slot clock configuration bit
    localparam int WIDTH_LSB = 4; // link width field low bit
    localparam int WIDTH_W = 6; // link width field width
    localparam logic [5:0] WIDTH_X0 = 6'h00; // port absorbed by a merge
    localparam logic [5:0] WIDTH_X4 = 6'h04; // separate x4 port
    localparam logic [5:0] WIDTH_X8 = 6'h08; // merged x8 port
    localparam logic [3:0] SCLK_RST = 4'h0; // slot clock bits in reset

    // ============================================================
    // strap status register fields
    // ============================================================
    localparam int ST_MODE_LSB = 0; // captured mode code, 3 bits
    localparam int ST_EEPROM = 3; // eeprom initialisation mode
    localparam int ST_RSVD = 4; // reserved mode code captured
    localparam int ST_MRG01 = 5; // ports 0 and 1 merged
    localparam int ST_MRG23 = 6; // ports 2 and 3 merged
    localparam int ST_CCDS = 7; // captured downstream common clock
    localparam int ST_CCUS = 8; // captured upstream common clock
    localparam int ST_VALID = 9; // straps captured since reset

    // ============================================================
    // operating mode codes
    // ============================================================
    localparam logic [2:0] MODE_NORMAL = 3'h0; // normal switch mode
    localparam logic [2:0] MODE_EEPROM = 3'h1; // normal with eeprom load
    localparam logic [2:0] MODE_RST = 3'h0; // captured mode in reset

    // ============================================================
    // synchroniser bit layout and reset value
    // ============================================================
    localparam int SY_CCDS = 0; // downstream common clock strap
    localparam int SY_CCUS = 1; // upstream common clock strap
    localparam int SY_M01N = 2; // port 0/1 merge strap, low active
    localparam int SY_M23N = 3; // port 2/3 merge strap, low active
    localparam int SY_MODE = 4; // mode strap, 3 bits
    localparam int SY_FRSTN = 7; // fundamental reset, low active
    localparam logic [7:0] SYNC_RST = 8'h0c; // merges off, reset held

    // ============================================================
    // bus responses
    // ============================================================
    localparam logic [1:0] RESP_OKAY = 2'h0; // access done
    localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

    // reset sequencing phases
    typedef enum logic [1:0] {
        PH_RESET = 2'b00,
        PH_CAPTURE = 2'b01,
        PH_RUN = 2'b10
    } ssr_phase_t;

endpackage

// *** ssr_sync.sv ***
`timescale 1ns/1ps
// ============================================================
// two-flop synchroniser for board straps and reset pin
// ============================================================
module ssr_sync
    import ssr_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic [7:0] d, // raw pin levels
    output logic [7:0] q // synchronised levels
);

    logic [7:0] meta_q; // first stage, read only by second stage

    // both stages in one process
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= SYNC_RST;
            q <= SYNC_RST;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// *** ssr_strap_reset_config.sv ***
`timescale 1ns/1ps
// Contract
// [RULE1] downstream common clock strap seeds downstream slot clock
// [RULE2] upstream common clock strap seeds upstream slot clock
// [RULE3] software writes override downstream slot clock bits
// [RULE4] software write overrides upstream slot clock bit
// [RULE5] low merge strap joins ports 0,1 x8
// [RULE6] low merge strap joins ports 2,3 x8
// [RULE7] fundamental reset clears logic, resets links
// [RULE8] mode 0 normal, 1 eeprom, rest reserved
// [RULE9] board keeps mode straps steady after reset
// [RULE10] straps captured at reset release, then held
module ssr_strap_reset_config
    import ssr_pkg::*;
(
    input wire logic aclk, // 40 mhz system clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic fundamental_reset_n, // board fundamental reset pin
    input wire logic common_clock_downstream, // downstream common clock strap
    input wire logic common_clock_upstream, // upstream common clock strap
    input wire logic merge_ports_zero_one_n, // port 0/1 merge strap
    input wire logic merge_ports_two_three_n, // port 2/3 merge strap
    input wire logic [2:0] switch_operating_select, // mode strap
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    output logic link_fund_reset, // serial links held in reset
    output logic straps_valid, // straps captured and in force
    output logic port0_width_x8, // port 0 takes port 1 lanes as 4..7
    output logic port1_enable, // port 1 runs as its own x4
    output logic port2_width_x8, // port 2 takes port 3 lanes as 4..7
    output logic port3_enable, // port 3 runs as its own x4
    output logic normal_mode, // normal switch mode selected
    output logic eeprom_init_req, // load configuration from eeprom
    output logic mode_reserved // reserved mode code on straps
);

    // ============================================================
    // helper functions
    // ============================================================
    // byte address to register index
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        logic [2:0] r;
        r = IDX_NONE;
        case (a)
            ADDR_LSTS0: r = 3'h0;
            ADDR_LSTS1: r = 3'h1;
            ADDR_LSTS2: r = 3'h2;
            ADDR_LSTS3: r = 3'h3;
            ADDR_STRAP: r = IDX_STRAP;
            default: r = IDX_NONE;
        endcase
        return r;
    endfunction

    // mode code is eeprom initialisation
    function automatic logic mode_is_eeprom(input logic [2:0] m);
        return m == MODE_EEPROM;
    endfunction

    // mode code is one of the reserved ones
    function automatic logic mode_is_rsvd(input logic [2:0] m);
        return (m != MODE_NORMAL) && (m != MODE_EEPROM);
    endfunction

    // ============================================================
    // pin synchronisation
    // ============================================================
    logic [7:0] pins_raw; // raw board pins
    logic [7:0] pins_s; // pins after two flops
    logic frst_s; // synced fundamental reset, low active
    logic int_rst; // internal logic reset
    logic [2:0] mode_s; // synced mode strap

    assign pins_raw = {fundamental_reset_n, switch_operating_select,
                       merge_ports_two_three_n, merge_ports_zero_one_n,
                       common_clock_upstream, common_clock_downstream};

    ssr_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pins_raw),
        .q(pins_s)
    );

    assign frst_s = pins_s[SY_FRSTN];
    assign mode_s = pins_s[SY_MODE +: 3];
    assign int_rst = !aresetn || !frst_s; // [RULE7]

    // ============================================================
    // reset phase sequencer
    // ============================================================
    ssr_phase_t phase_q; // current phase
    logic capture; // one-cycle strap capture strobe

    // reset, capture one cycle after release, then run
    always_ff @(posedge aclk)
    begin
        if (int_rst)
        begin
            phase_q <= PH_RESET; // [RULE7]
        end
        else
        begin
            case (phase_q)
                PH_RESET: phase_q <= PH_CAPTURE;
                PH_CAPTURE: phase_q <= PH_RUN;
                PH_RUN: phase_q <= PH_RUN;
                default: phase_q <= PH_RESET;
            endcase
        end
    end

    assign capture = (phase_q == PH_CAPTURE);

    // links stay in fundamental reset until straps are in force
    always_ff @(posedge aclk)
    begin
        if (int_rst)
        begin
            link_fund_reset <= 1'b1; // [RULE7]
        end
        else if (capture)
        begin
            link_fund_reset <= 1'b0;
        end
    end

    // ============================================================
    // captured straps
    // ============================================================
    logic merge01_q; // ports 0/1 merged
    logic merge23_q; // ports 2/3 merged
    logic [2:0] mode_q; // captured mode code
    logic ccds_q; // captured downstream common clock
    logic ccus_q; // captured upstream common clock

    // capture once per release; later strap motion is ignored
    always_ff @(posedge aclk)
    begin
        if (int_rst)
        begin
            straps_valid <= 1'b0;
            merge01_q <= 1'b0;
            merge23_q <= 1'b0;
            mode_q <= MODE_RST;
            ccds_q <= 1'b0;
            ccus_q <= 1'b0;
            normal_mode <= 1'b0;
            eeprom_init_req <= 1'b0;
            mode_reserved <= 1'b0;
        end
        else if (capture)
        begin
            // mode pins are assumed steady from here on [RULE9]
            straps_valid <= 1'b1; // [RULE10]
            merge01_q <= !pins_s[SY_M01N]; // [RULE5]
            merge23_q <= !pins_s[SY_M23N]; // [RULE6]
            mode_q <= mode_s; // [RULE10]
            ccds_q <= pins_s[SY_CCDS];
            ccus_q <= pins_s[SY_CCUS];
            normal_mode <= !mode_is_rsvd(mode_s); // [RULE8]
            eeprom_init_req <= mode_is_eeprom(mode_s); // [RULE8]
            mode_reserved <= mode_is_rsvd(mode_s); // [RULE8]
        end
    end

    // lane ownership follows the merge straps
    assign port0_width_x8 = merge01_q; // [RULE5]
    assign port1_enable = straps_valid && !merge01_q; // [RULE5]
    assign port2_width_x8 = merge23_q; // [RULE6]
    assign port3_enable = straps_valid && !merge23_q; // [RULE6]

    // ============================================================
    // bus write path
    // ============================================================
    logic aw_full_q; // write address held
    logic [7:0] aw_addr_q; // held write address
    logic w_full_q; // write data held
    logic [31:0] w_data_q; // held write data
    logic [3:0] w_strb_q; // held byte enables
    logic wr_do; // both halves present, perform write
    logic [2:0] wr_idx; // decoded write index

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr_q);

    // address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_do)
            begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_do)
            begin
                w_full_q <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_do)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ============================================================
    // slot clock configuration bits
    // ============================================================
    logic [3:0] sclk_q; // per-port slot clock bit, index 0 upstream

    // strap seeds at capture, software replaces afterwards
    always_ff @(posedge aclk)
    begin
        if (int_rst)
        begin
            sclk_q <= SCLK_RST;
        end
        else if (capture)
        begin
            sclk_q[3:1] <= {3{pins_s[SY_CCDS]}}; // [RULE1]
            sclk_q[0] <= pins_s[SY_CCUS]; // [RULE2]
        end
        else if (wr_do && (wr_idx < IDX_STRAP) && w_strb_q[SCLK_BIT / 8])
        begin
            sclk_q[wr_idx[1:0]] <= w_data_q[SCLK_BIT]; // [RULE3] [RULE4]
        end
    end

    // ============================================================
    // bus read path
    // ============================================================
    // read word for a register index
    function automatic logic [31:0] rd_word(input logic [2:0] idx);
        logic [31:0] w;
        logic [5:0] wd;
        w = 32'h0000_0000;
        wd = WIDTH_X0;
        case (idx)
            3'h0: wd = merge01_q ? WIDTH_X8 : WIDTH_X4;
            3'h1: wd = merge01_q ? WIDTH_X0 : WIDTH_X4;
            3'h2: wd = merge23_q ? WIDTH_X8 : WIDTH_X4;
            3'h3: wd = merge23_q ? WIDTH_X0 : WIDTH_X4;
            default: wd = WIDTH_X0;
        endcase
        if (idx < IDX_STRAP)
        begin
            w[SCLK_BIT] = sclk_q[idx[1:0]];
            w[WIDTH_LSB +: WIDTH_W] = straps_valid ? wd : WIDTH_X0;
        end
        else if (idx == IDX_STRAP)
        begin
            w[ST_MODE_LSB +: 3] = mode_q;
            w[ST_EEPROM] = eeprom_init_req;
            w[ST_RSVD] = mode_reserved;
            w[ST_MRG01] = merge01_q;
            w[ST_MRG23] = merge23_q;
            w[ST_CCDS] = ccds_q;
            w[ST_CCUS] = ccus_q;
            w[ST_VALID] = straps_valid;
        end
        return w;
    endfunction

    assign s_axi_arready = !s_axi_rvalid;

    // read data registered one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word(reg_index(s_axi_araddr));
            s_axi_rresp <= (reg_index(s_axi_araddr) == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // assertions
    // ============================================================
    a_ds_sclk_seed: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
        (capture && !int_rst) |=> (sclk_q[3:1] == {3{$past(pins_s[SY_CCDS])}}))
        else $error("downstream slot clock not seeded from strap");

    a_us_sclk_seed: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
        (capture && !int_rst) |=> (sclk_q[0] == $past(pins_s[SY_CCUS])))
        else $error("upstream slot clock not seeded from strap");

    a_ds_sclk_write: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
        (wr_do && !int_rst && !capture && wr_idx == 3'h2 && w_strb_q[1])
        ##1 frst_s |-> (sclk_q[2] == $past(w_data_q[SCLK_BIT])))
        else $error("downstream slot clock write lost");

    a_us_sclk_write: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
        (wr_do && !int_rst && !capture && wr_idx == 3'h0 && w_strb_q[1])
        ##1 frst_s |-> (sclk_q[0] == $past(w_data_q[SCLK_BIT])))
        else $error("upstream slot clock write lost");

    a_merge01_lanes: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
        (capture && !int_rst) |=> (port0_width_x8 == !$past(pins_s[SY_M01N]))
        && (port1_enable == $past(pins_s[SY_M01N])))
        else $error("port 0/1 merge does not follow strap");

    a_merge23_lanes: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
        (capture && !int_rst) |=> (port2_width_x8 == !$past(pins_s[SY_M23N]))
        && (port3_enable == $past(pins_s[SY_M23N])))
        else $error("port 2/3 merge does not follow strap");

    a_fund_rst_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
        !frst_s |=> link_fund_reset && !straps_valid && (sclk_q == SCLK_RST)
        ##1 link_fund_reset)
        else $error("fundamental reset did not clear logic");

    a_mode_decode: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
        (capture && !int_rst) |=> (eeprom_init_req == ($past(mode_s) == MODE_EEPROM))
        && (mode_reserved == ($past(mode_s) > MODE_EEPROM))
        && (normal_mode == ($past(mode_s) <= MODE_EEPROM)))
        else $error("mode strap decoded wrongly");

    a_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
        (straps_valid && frst_s) |=> !frst_s || ($stable(mode_q) && $stable(merge01_q)
        && $stable(merge23_q) && straps_valid))
        else $error("captured straps changed without reset");

endmodule

// *** ssr_board_model.sv ***
`timescale 1ns/1ps
// ============================================================
// board strap wiring and fundamental reset driver
// ============================================================
module ssr_board_model (
    input wire logic aclk, // system clock
    input wire logic req_rst_n, // reset level asked by the bench
    input wire logic [6:0] req_straps, // strap levels asked by the bench
    output logic fundamental_reset_n, // board reset pin
    output logic [6:0] straps // {mode, merge23_n, merge01_n, ccus, ccds}
);
    // clock and merge straps follow the board, mode only under reset
    always @(posedge aclk)
    begin
        fundamental_reset_n <= req_rst_n;
        straps[3:0] <= req_straps[3:0];
        if (fundamental_reset_n !== 1'b1)
        begin
            straps[6:4] <= req_straps[6:4];
        end
    end
endmodule

// *** test_switch_strap_reset_config.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ============================================================
// strap capture, decode and link status bench
// ============================================================
module test_switch_strap_reset_config
    import ssr_pkg::*;
;
    logic aclk, aresetn, req_rst_n, frst_n; // clock, resets
    logic [6:0] req_straps, straps, s; // strap levels
    logic [7:0] s_axi_awaddr, s_axi_araddr; // bus addresses
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd, ev; // bus data
    logic [3:0] s_axi_wstrb; // byte enables
    logic [1:0] s_axi_bresp, s_axi_rresp, rr; // responses
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, link_fund_reset, straps_valid;
    logic port0_width_x8, port1_enable, port2_width_x8, port3_enable;
    logic normal_mode, eeprom_init_req, mode_reserved; // decoded mode
    int fail_count, cmp_count; // counters
    int cyc = 0; // watchdog cycles

    ssr_strap_reset_config dut_u (
        .aclk, .aresetn, .fundamental_reset_n(frst_n),
        .common_clock_downstream(straps[0]), .common_clock_upstream(straps[1]),
        .merge_ports_zero_one_n(straps[2]), .merge_ports_two_three_n(straps[3]),
        .switch_operating_select(straps[6:4]),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .link_fund_reset, .straps_valid,
        .port0_width_x8, .port1_enable, .port2_width_x8, .port3_enable,
        .normal_mode, .eeprom_init_req, .mode_reserved
    );
    ssr_board_model board_u (.aclk, .req_rst_n, .req_straps,
        .fundamental_reset_n(frst_n), .straps);

    // ============================================================
    // clock and watchdog
    // ============================================================
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // cut a hang short
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            summarize();
        end
    end

    // ============================================================
    // expectations
    // ============================================================
    // link status: slot clock bit and width field
    function automatic logic [31:0] exp_lsts(input int p, input logic [6:0] t);
        logic m;
        logic [31:0] v;
        m = (p < 2) ? !t[2] : !t[3];
        v = 32'h0;
        v[12] = (p == 0) ? t[1] : t[0];
        v[9:4] = (p[0] == 1'b0) ? (m ? WIDTH_X8 : WIDTH_X4) : (m ? WIDTH_X0 : WIDTH_X4);
        return v;
    endfunction
    // strap status word
    function automatic logic [31:0] exp_strap(input logic [6:0] t);
        return {22'h0, 1'b1, t[1], t[0], !t[3], !t[2], t[6:4] > 3'h1, t[6:4] == 3'h1, t[6:4]};
    endfunction

    // ============================================================
    // bus and board tasks
    // ============================================================
    // one write, both halves offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one read
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // fundamental reset with new straps, then wait for capture
    task automatic cap(input logic [6:0] t);
        req_rst_n <= 1'b0;
        req_straps <= t;
        repeat (4) @(posedge aclk);
        axr(ADDR_LSTS0, rd, rr);
        `CHK({link_fund_reset, straps_valid, rd & 32'h13f0}, {2'b10, 32'h0})
        req_rst_n <= 1'b1;
        do @(posedge aclk); while (straps_valid !== 1'b1);
    endtask
    // port and mode outputs against captured straps
    task automatic chk_out(input logic [6:0] t);
        logic [2:0] m;
        m = t[6:4];
        `CHK({port0_width_x8, port1_enable, port2_width_x8, port3_enable}, {!t[2], t[2], !t[3], t[3]})
        `CHK({normal_mode, eeprom_init_req, mode_reserved}, {m<3'h2, m==3'h1, m>3'h1})
        `CHK(link_fund_reset, 1'b0)
    endtask
    // counts and verdict
    task automatic summarize();
        $display("counts: compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ============================================================
    // main sequence
    // ============================================================
    initial
    begin
        {aresetn, req_rst_n, req_straps, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {fail_count, cmp_count} = '0;
        void'($urandom(32'h4e32));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK({link_fund_reset, straps_valid}, 2'b10)
        // every mode code, random straps, two corner sets
        for (int i = 0; i < 10; i++)
        begin
            s = 7'($urandom);
            s[6:4] = i[2:0];
            if (i > 7) s = (i == 8) ? 7'h10 : 7'h0f;
            cap(s);
            chk_out(s);
            axr(ADDR_STRAP, rd, rr);
            `CHK(rd & 32'h3ff, exp_strap(s))
            for (int p = 0; p < 4; p++)
            begin
                axr(8'(p * 4), rd, rr);
                `CHK(rd & 32'h13f0, exp_lsts(p, s))
                `CHK(rr, RESP_OKAY)
                ev = exp_lsts(p, s);
                ev[12] = ~ev[12];
                wd = $urandom;
                wd[12] = ev[12];
                axw(8'(p * 4), wd, rr);
                `CHK(rr, RESP_OKAY)
                axr(8'(p * 4), rd, rr);
                `CHK(rd & 32'h13f0, ev)
                // a write without the slot clock byte lane leaves the bit alone
                s_axi_wstrb <= 4'hd;
                axw(8'(p * 4), ~wd, rr);
                s_axi_wstrb <= 4'hf;
                axr(8'(p * 4), rd, rr);
                `CHK(rd & 32'h13f0, ev)
            end
            // pins move after capture, outputs must not
            req_straps <= ~s;
            axw(ADDR_STRAP, 32'h0, rr);
            `CHK(rr, RESP_OKAY)
            repeat (8) @(posedge aclk);
            chk_out(s);
            axr(ADDR_STRAP, rd, rr);
            `CHK(rd & 32'h3ff, exp_strap(s))
            $display("test %0d done", i);
        end
        // unmapped place answers with an error
        axr(8'h14, rd, rr);
        `CHK({rr, rd}, {RESP_SLVERR, 32'h0})
        axw(8'h14, 32'h0, rr);
        `CHK(rr, RESP_SLVERR)
        $display("test unmapped done");
        summarize();
    end
endmodule
